// [shared/vic_pkg.sv]
// Package: register map, field layout, timing counts and carrier types of the interrupt controller
package vic_pkg;

	localparam int          NUM_TRAPS       = 8;
	localparam int          NUM_IRQS        = 24;
	localparam int          NUM_SRCS        = 32;
	localparam int          NUM_GEN         = 20;

	// Register byte offsets
	localparam logic [11:0] OFF_CTRL_TWO    = 12'h000;
	localparam logic [11:0] OFF_ENABLE_GEN  = 12'h004;
	localparam logic [11:0] OFF_ENABLE_FOUR = 12'h008;
	localparam logic [11:0] OFF_ENABLE_FIVE = 12'h00C;
	localparam logic [11:0] OFF_PRIO0       = 12'h010;
	localparam logic [11:0] OFF_PRIO1       = 12'h014;
	localparam logic [11:0] OFF_PRIO2       = 12'h018;
	localparam logic [11:0] OFF_STATUS      = 12'h01C;
	localparam logic [3:0]  TABLE_PAGE      = 4'h1;

	// Field positions
	localparam int          POS_ALT_SEL     = 15;
	localparam int          POS_VDET_EN     = 8;
	localparam int          POS_SER2_EN     = 2;
	localparam int          POS_SER1_EN     = 1;
	localparam int          POS_WAKE_EN     = 0;
	localparam logic [31:0] MASK_FOUR       = 32'h0000_0106;
	localparam logic [31:0] MASK_FIVE       = 32'h0000_0001;

	// Interrupt numbers of the named sources
	localparam int          IRQ_SER1_ERR    = 20;
	localparam int          IRQ_SER2_ERR    = 21;
	localparam int          IRQ_VDET        = 22;
	localparam int          IRQ_WAKE        = 23;

	// Program-space layout of the vector tables
	localparam logic [23:0] RESET_ADDR      = 24'h000000;
	localparam logic [23:0] PRIMARY_BASE    = 24'h000004;
	localparam logic [23:0] TABLE_ENTRIES   = 24'h00007E;
	localparam logic [23:0] ALT_BASE        = PRIMARY_BASE + (TABLE_ENTRIES << 1);
	localparam logic [3:0]  TRAP_LEVEL      = 4'h8;

	// Fixed latencies in clock cycles
	localparam logic [3:0]  ENTRY_CYCLES    = 4'h5;
	localparam logic [3:0]  RETURN_CYCLES   = 4'h3;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_REQ   = 3'b001,
		ST_ENTER = 3'b010,
		ST_SVC   = 3'b011,
		ST_RET   = 3'b100
	} vic_state_t;

	typedef struct packed {
		logic       ack;
		logic       ret;
		logic [2:0] ipl;
	} vic_core_in_t;

	typedef struct packed {
		logic        req;
		logic [4:0]  vec;
		logic [3:0]  level;
		logic [23:0] fetch_addr;
		logic [23:0] handler;
		logic        entered;
		logic        busy;
	} vic_core_out_t;

endpackage : vic_pkg

// [rtl/vic_top.sv]
// Vectored interrupt controller with APB register file and dual vector table
`timescale 1ns/1ps

// Function
// - All peripheral requests merge into one request toward the core.
// - Eight trap sources are handled besides the peripheral interrupts.
// - Each maskable source gets one of seven priority levels from software.
// - Ties within one level resolve by fixed order, never dynamically.
// - Lower vector number wins a tie; vector zero beats all.
// - Primary table starts at 000004h, 126 entries: 8 traps, 118 interrupts.
// - Each entry holds a 24-bit handler address sent to the core.
// - Every source owns one distinct vector entry.
// - Thirty-two trap and interrupt sources are implemented.
// - Alternate select bit 15 of control two switches to the alternate table.
// - Alternate table keeps the same layout and source order.
// - Entry and return take a fixed number of cycles.
// - Reset is no exception; the controller plays no part in it.
// - Reset points fetch at address 000000h.
// - Enable five bit 0 gates low-power wake; bits 15-1 read zero.
module vic_top
	import vic_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [NUM_TRAPS-1:0] trap_req,
	input  wire logic [NUM_IRQS-1:0] irq_req,
	input  wire vic_core_in_t        core_in,
	output vic_core_out_t            core_out
);

	typedef struct packed {
		logic                          alt_sel;
		logic [NUM_GEN-1:0]            en_gen;
		logic                          en_vdet;
		logic                          en_ser2;
		logic                          en_ser1;
		logic                          en_wake;
		logic [NUM_IRQS-1:0][2:0]      prio;
		logic [2*NUM_SRCS-1:0][23:0]   table_mem;
		vic_state_t                    state;
		logic [3:0]                    cnt;
		vic_core_out_t                 co;
		logic [31:0]                   rdata;
		logic                          ready;
		logic                          err;
	} vic_regs_t;

	vic_regs_t state_reg;
	vic_regs_t state_next;

	logic [NUM_IRQS-1:0] irq_en;
	logic                win_valid;
	logic [4:0]          win_vec;
	logic [3:0]          win_level;
	logic                access;
	logic                setup;

	////////////////////////////////////////////////////////////////////////////////

	function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
		return addr == off;
	endfunction : hit

	// Packs one priority register; upper bit of each nibble reads zero
	function automatic logic [31:0] prio_word(input logic [NUM_IRQS-1:0][2:0] p,
	                                          input int base);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int i = 0; i < 8; i++) begin
			w[4*i +: 3] = p[base + i];
		end
		return w;
	endfunction : prio_word

	////////////////////////////////////////////////////////////////////////////////

	assign irq_en = {state_reg.en_wake, state_reg.en_vdet, state_reg.en_ser2,
	                 state_reg.en_ser1, state_reg.en_gen};

	// Traps sit above every user level; strict compare keeps the lowest vector on ties
	always_comb begin
		win_valid = 1'b0;
		win_vec   = 5'h00;
		win_level = 4'h0;
		for (int s = 0; s < NUM_SRCS; s++) begin
			logic [3:0] lv;
			logic       ok;
			lv = 4'h0;
			ok = 1'b0;
			if (s < NUM_TRAPS) begin
				lv = TRAP_LEVEL;
				ok = trap_req[s];
			end else begin
				lv = {1'b0, state_reg.prio[s-NUM_TRAPS]};
				ok = irq_req[s-NUM_TRAPS] && irq_en[s-NUM_TRAPS]
				     && (lv != 4'h0) && (lv > {1'b0, core_in.ipl});
			end
			if (ok && (!win_valid || lv > win_level)) begin
				win_valid = 1'b1;
				win_vec   = 5'(s);
				win_level = lv;
			end
		end
	end

	assign setup  = psel && !penable;
	assign access = psel && penable && state_reg.ready;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic [5:0] widx;
		widx       = {paddr[7:2]};
		state_next = state_reg;
		state_next.co.entered = 1'b0;

		// Zero-wait slave: pready rises the cycle after setup, read data is prepared then
		state_next.ready = setup;
		state_next.err   = 1'b0;
		if (setup) begin
			state_next.rdata = 32'h0000_0000;
			if (hit(paddr, OFF_CTRL_TWO)) begin
				state_next.rdata[POS_ALT_SEL] = state_reg.alt_sel;
			end else if (hit(paddr, OFF_ENABLE_GEN)) begin
				state_next.rdata[NUM_GEN-1:0] = state_reg.en_gen;
			end else if (hit(paddr, OFF_ENABLE_FOUR)) begin
				state_next.rdata[POS_VDET_EN] = state_reg.en_vdet;
				state_next.rdata[POS_SER2_EN] = state_reg.en_ser2;
				state_next.rdata[POS_SER1_EN] = state_reg.en_ser1;
			end else if (hit(paddr, OFF_ENABLE_FIVE)) begin
				state_next.rdata[POS_WAKE_EN] = state_reg.en_wake;
			end else if (hit(paddr, OFF_PRIO0)) begin
				state_next.rdata = prio_word(state_reg.prio, 0);
			end else if (hit(paddr, OFF_PRIO1)) begin
				state_next.rdata = prio_word(state_reg.prio, 8);
			end else if (hit(paddr, OFF_PRIO2)) begin
				state_next.rdata = prio_word(state_reg.prio, 16);
			end else if (hit(paddr, OFF_STATUS)) begin
				state_next.rdata[2:0]   = state_reg.state;
				state_next.rdata[12:8]  = state_reg.co.vec;
				state_next.rdata[19:16] = state_reg.co.level;
			end else if (paddr[11:8] == TABLE_PAGE) begin
				state_next.rdata[23:0] = state_reg.table_mem[widx];
			end else begin
				state_next.err = 1'b1;
			end
		end

		// Writes land only at the edge that completes the access phase
		if (access && pwrite) begin
			if (hit(paddr, OFF_CTRL_TWO)) begin
				state_next.alt_sel = pwdata[POS_ALT_SEL];
			end else if (hit(paddr, OFF_ENABLE_GEN)) begin
				state_next.en_gen = pwdata[NUM_GEN-1:0];
			end else if (hit(paddr, OFF_ENABLE_FOUR)) begin
				state_next.en_vdet = pwdata[POS_VDET_EN];
				state_next.en_ser2 = pwdata[POS_SER2_EN];
				state_next.en_ser1 = pwdata[POS_SER1_EN];
			end else if (hit(paddr, OFF_ENABLE_FIVE)) begin
				state_next.en_wake = pwdata[POS_WAKE_EN];
			end else if (hit(paddr, OFF_PRIO0) || hit(paddr, OFF_PRIO1)
			             || hit(paddr, OFF_PRIO2)) begin
				// Word 0, 1 and 2 of the priority block hold interrupts 0-7, 8-15 and 16-23
				for (int i = 0; i < 8; i++) begin
					state_next.prio[8*int'(paddr[3:2]) + i] = pwdata[4*i +: 3];
				end
			end else if (paddr[11:8] == TABLE_PAGE) begin
				state_next.table_mem[widx] = pwdata[23:0];
			end
		end

		case (state_reg.state)
			ST_IDLE: begin
				if (win_valid) begin
					state_next.state         = ST_REQ;
					state_next.co.req        = 1'b1;
					state_next.co.vec        = win_vec;
					state_next.co.level      = win_level;
					state_next.co.fetch_addr = (state_reg.alt_sel ? ALT_BASE : PRIMARY_BASE)
					                           + {18'h00000, win_vec, 1'b0};
				end
			end
			ST_REQ: begin
				// Request is held as latched; a later, higher source waits for the next round
				if (core_in.ack) begin
					state_next.state   = ST_ENTER;
					state_next.co.req  = 1'b0;
					state_next.co.busy = 1'b1;
					state_next.cnt     = ENTRY_CYCLES - 4'h1;
					state_next.co.handler =
						state_reg.table_mem[{state_reg.alt_sel, state_reg.co.vec}];
				end
			end
			ST_ENTER: begin
				if (state_reg.cnt == 4'h0) begin
					state_next.state      = ST_SVC;
					state_next.co.entered = 1'b1;
				end else begin
					state_next.cnt = state_reg.cnt - 4'h1;
				end
			end
			ST_SVC: begin
				if (core_in.ret) begin
					state_next.state = ST_RET;
					state_next.cnt   = RETURN_CYCLES - 4'h1;
				end
			end
			ST_RET: begin
				if (state_reg.cnt == 4'h0) begin
					state_next.state   = ST_IDLE;
					state_next.co.busy = 1'b0;
				end else begin
					state_next.cnt = state_reg.cnt - 4'h1;
				end
			end
			default: begin
				state_next.state = ST_IDLE;
			end
		endcase
	end

	// Reset only clears state; fetch address parks at the reset location
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg               <= '0;
			state_reg.state         <= ST_IDLE;
			state_reg.co.fetch_addr <= RESET_ADDR;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata   = state_reg.rdata;
	assign pready   = state_reg.ready;
	assign pslverr  = state_reg.err;
	assign core_out = state_reg.co;

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_req_hold:    assert property (core_out.req && !core_in.ack |=> core_out.req
		&& $stable(core_out.vec)) else $error("request dropped before ack");
	a_entry_fixed: assert property (core_out.req && core_in.ack |-> ##6 core_out.entered)
		else $error("entry latency wrong");
	a_ret_fixed:   assert property (state_reg.state == ST_SVC && core_in.ret
		|-> ##1 state_reg.state == ST_RET [*3] ##1 state_reg.state == ST_IDLE)
		else $error("return latency wrong");
	a_fetch_addr:  assert property (core_out.req |-> core_out.fetch_addr ==
		(state_reg.alt_sel ? ALT_BASE : PRIMARY_BASE) + {18'h00000, core_out.vec, 1'b0})
		else $error("fetch address mismatch");
	a_handler_sel: assert property (core_out.entered |-> core_out.handler ==
		state_reg.table_mem[{state_reg.alt_sel, core_out.vec}])
		else $error("handler from wrong table");
	a_trap_first:  assert property (state_reg.state == ST_IDLE && (|trap_req)
		|=> core_out.req && core_out.vec < 5'h08) else $error("trap lost arbitration");
	a_masked_off:  assert property (state_reg.state == ST_IDLE && !(|trap_req)
		&& !(|(irq_req & irq_en)) |=> !core_out.req) else $error("masked source won");
	a_four_zero:   assert property (pready && hit(paddr, OFF_ENABLE_FOUR)
		|-> (prdata & ~MASK_FOUR) == 32'h0000_0000) else $error("enable four reserved bits");
	a_five_zero:   assert property (pready && hit(paddr, OFF_ENABLE_FIVE)
		|-> (prdata & ~MASK_FIVE) == 32'h0000_0000) else $error("enable five reserved bits");

	// No nesting: one request toward the core at a time
	a_busy_no_req: assert property (core_out.busy |-> !core_out.req)
		else $error("request raised while busy");
	a_trap_level:  assert property (core_out.req && core_out.vec < 5'h08
		|-> core_out.level == TRAP_LEVEL) else $error("trap level wrong");
	a_user_level:  assert property (core_out.req && core_out.vec >= 5'h08
		|-> core_out.level != 4'h0 && core_out.level < TRAP_LEVEL) else $error("user level wrong");
	a_ipl_gate:    assert property ($rose(core_out.req) && core_out.vec >= 5'h08
		|-> core_out.level > {1'b0, $past(core_in.ipl)}) else $error("request at or below ipl");
	a_handler_hold: assert property (core_out.busy && !core_in.ack
		|=> $stable(core_out.handler)) else $error("handler changed in service");
	a_wake_gate:   assert property (state_reg.state == ST_IDLE && !state_reg.en_wake
		&& irq_req == 24'h80_0000 && !(|trap_req) |=> !core_out.req) else $error("wake not gated");

	c_trap_served: cover property (core_out.req && core_out.vec < 5'h08 ##1 core_in.ack);
	c_alt_entry:   cover property (state_reg.alt_sel && core_out.entered);
	c_full_round:  cover property (core_out.entered ##[1:50] state_reg.state == ST_RET);
	c_ipl_held:    cover property (irq_req[5] && core_in.ipl == 3'h7 && state_reg.state == ST_IDLE);

endmodule : vic_top

// [sim/vic_core_model.sv]
// Behavioural processor core that takes one vectored request at a time
`timescale 1ns/1ps
module vic_core_model
	import vic_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire vic_core_out_t core_out,
	input  wire logic [2:0]    ipl_set,
	input  wire logic [1:0]    ack_dly,
	output vic_core_in_t       core_in,
	output logic [23:0]        fetch_seen,
	output logic [3:0]         lat
);
	logic [1:0] dly_cnt;
	logic [1:0] svc_cnt;
	// Ack may lag req by up to four cycles, like a core finishing an instruction
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_in <= '0;
			dly_cnt <= '0;
			svc_cnt <= '0;
			fetch_seen <= '0;
			lat <= '0;
		end else begin
			core_in.ack <= 1'b0;
			core_in.ret <= 1'b0;
			core_in.ipl <= ipl_set;
			if (core_out.req && !core_in.ack) begin
				dly_cnt <= dly_cnt + 2'h1;
				if (dly_cnt == ack_dly) begin
					core_in.ack <= 1'b1;
					dly_cnt <= '0;
				end
			end
			// Entry latency counted from the ack edge
			if (core_in.ack) begin
				fetch_seen <= core_out.fetch_addr;
				lat <= 4'h1;
			end else if (core_out.entered) begin
				lat <= '0;
			end else if (lat != 4'h0) begin
				lat <= lat + 4'h1;
			end
			if (core_out.entered) begin
				svc_cnt <= 2'h3;
			end else if (svc_cnt != 2'h0) begin
				svc_cnt <= svc_cnt - 2'h1;
				core_in.ret <= (svc_cnt == 2'h1);
			end
		end
	end
endmodule : vic_core_model

// [sim/test_vectored_interrupt_controller.sv]
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module test_vectored_interrupt_controller
	import vic_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, alt;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] trap_req;
	logic [23:0] irq_req, fetch_seen;
	logic [23:0] hp[32];
	logic [23:0] ha[32];
	logic [2:0] ipl_set;
	logic [1:0] ack_dly;
	logic [3:0] lat;
	vic_core_in_t core_in;
	vic_core_out_t core_out;
	logic [32:0] rdq[$];
	logic [60:0] irqq[$];
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	localparam int EB[4] = '{POS_SER1_EN, POS_SER2_EN, POS_VDET_EN, POS_WAKE_EN};
	localparam logic [3:0] LV[4] = '{4'h1, 4'h2, 4'h4, 4'h5};

	vic_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .trap_req(trap_req), .irq_req(irq_req), .core_in(core_in),
		.core_out(core_out));
	vic_core_model core (.pclk(pclk), .presetn(presetn), .core_out(core_out),
		.ipl_set(ipl_set), .ack_dly(ack_dly), .core_in(core_in), .fetch_seen(fetch_seen),
		.lat(lat));

	always #2.5 pclk = ~pclk;

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Result watcher: oldest note against what appears
	always @(posedge pclk) begin : watch
		logic [60:0] e;
		logic [32:0] r;
		if (presetn && psel && penable && pready === 1'b1 && !pwrite) begin
			r = rdq.pop_front();
			`CHK("read", r, {pslverr, prdata})
		end
		if (presetn && core_out.entered === 1'b1) begin
			e = irqq.pop_front();
			`CHK("entry", e, {core_out.vec, core_out.level, fetch_seen, core_out.handler, lat})
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus and service tasks; each ends one edge after release so drivers never collide
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
		rdq.push_back({err, e});
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic serve(input logic [7:0] t, input logic [23:0] q, input logic [4:0] v,
		input logic [3:0] l);
		int n;
		logic [23:0] b;
		b = alt ? ALT_BASE : PRIMARY_BASE;
		irqq.push_back({v, l, b + {18'h0, v, 1'b0}, alt ? ha[v] : hp[v], 4'h6});
		trap_req <= t;
		irq_req <= q;
		ack_dly <= 2'($urandom);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (core_out.entered !== 1'b1);
		trap_req <= '0;
		irq_req <= '0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (core_out.busy !== 1'b0);
		// Model serves three cycles, ret is taken one edge later, idle is seen one edge after
		`CHK("return time", 5 + int'(RETURN_CYCLES), n)
		@(posedge pclk);
	endtask : serve

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] t;
		int v;
		void'($urandom(32'h59BD8080));
		{psel, penable, pwrite, paddr, pwdata} <= '0;
		{trap_req, irq_req, ipl_set, ack_dly, alt} <= '0;
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK("parked fetch", RESET_ADDR, core_out.fetch_addr)
		`CHK("idle request", 1'b0, core_out.req)
		for (int i = 0; i < 8; i++)
			rd(12'(4 * i), 32'h0, 1'b0);
		rd(12'h080, 32'h0, 1'b1);
		apb(1'b1, OFF_ENABLE_FOUR, 32'hFFFF_FFFF);
		rd(OFF_ENABLE_FOUR, MASK_FOUR, 1'b0);
		apb(1'b1, OFF_ENABLE_FIVE, 32'hFFFF_FFFF);
		rd(OFF_ENABLE_FIVE, MASK_FIVE, 1'b0);
		apb(1'b1, OFF_ENABLE_FOUR, 32'h0);
		apb(1'b1, OFF_ENABLE_FIVE, 32'h0);
		// Alternate entries differ from primary so a wrong table shows up
		for (int k = 0; k < 32; k++) begin
			hp[k] = 24'($urandom);
			ha[k] = 24'($urandom);
			apb(1'b1, 12'h100 + 12'(4 * k), {8'h00, hp[k]});
			apb(1'b1, 12'h180 + 12'(4 * k), {8'h00, ha[k]});
		end
		serve(8'h84, 24'h0, 5'd2, TRAP_LEVEL);
		apb(1'b1, OFF_ENABLE_GEN, 32'h000F_FFFF);
		apb(1'b1, OFF_PRIO0, 32'h0076_0063);
		serve(8'h00, 24'h000013, 5'd9, 4'h6);
		serve(8'h00, 24'h000021, 5'd13, 4'h7);
		serve(8'h80, 24'h000021, 5'd7, TRAP_LEVEL);
		// The core model registers ipl, so the level must settle before the request
		ipl_set <= 3'h7;
		@(posedge pclk);
		irq_req <= 24'h000020;
		repeat (8) @(posedge pclk);
		`CHK("held by ipl", 1'b0, core_out.req)
		ipl_set <= 3'h0;
		serve(8'h00, 24'h000020, 5'd13, 4'h7);
		apb(1'b1, OFF_PRIO2, 32'h5421_0000);
		for (int j = 0; j < 4; j++) begin
			irq_req <= 24'h1 << (20 + j);
			repeat (8) @(posedge pclk);
			`CHK("gated request", 1'b0, core_out.req)
			apb(1'b1, j == 3 ? OFF_ENABLE_FIVE : OFF_ENABLE_FOUR, 32'h1 << EB[j]);
			serve(8'h00, 24'h1 << (20 + j), 5'(28 + j), LV[j]);
			apb(1'b1, j == 3 ? OFF_ENABLE_FIVE : OFF_ENABLE_FOUR, 32'h0);
		end
		apb(1'b1, OFF_CTRL_TWO, 32'h0000_8000);
		alt = 1'b1;
		for (int r = 0; r < 6; r++) begin
			t = 8'($urandom);
			if (t == 8'h00)
				t = 8'h01;
			v = 0;
			while (!t[v])
				v++;
			serve(t, 24'($urandom), 5'(v), TRAP_LEVEL);
		end
		apb(1'b1, OFF_CTRL_TWO, 32'h0);
		alt = 1'b0;
		serve(8'h00, 24'h000002, 5'd9, 4'h6);
		// Alternate table unused again: mirror the primary handlers into it
		for (int k = 0; k < 32; k++)
			apb(1'b1, 12'h180 + 12'(4 * k), {8'h00, hp[k]});
		rd(12'h180, {8'h00, hp[0]}, 1'b0);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK("reset fetch", RESET_ADDR, core_out.fetch_addr)
		`CHK("reset busy", 1'b0, core_out.busy)
		`CHK("pending entries", 0, irqq.size())
		tally_and_finish();
	end
endmodule : test_vectored_interrupt_controller
